// *** design/phsp_pkg.sv ***
// Package of constants and types for the PCM highway serial port.
// Behaviour
// [RULE1] - Receive and transmit highway paths are timed independently with no phase relation.
// [RULE2] - The port runs 32-slot 2.048 Mbit/s framing and 24-slot 1.544 or 1.536 Mbit/s framing.
// [RULE3] - On a 4.096 Mbit/s highway only the even or only the odd slots are served.
// [RULE4] - A per-slot fill mask selects which bits of a slot are used, giving 64 to 8 kbit/s.
// [RULE5] - Any set of slots may be grouped into one logical channel of 8 kbit/s to 2.048 Mbit/s.
// [RULE6] - A sampled rising edge of the transmit sync marks the current transmit bit as the last.
// [RULE7] - A sampled rising edge of the receive sync marks the current receive bit as the first.
// [RULE8] - In 1.544 MHz framing the framing bit is ignored on receive and not driven on transmit.
// [RULE9] - Masked receive bits are dropped, except in transparent mode A where they read as ones.
// [RULE10] - The highway source gives each sync one rising and one falling edge per 125 us frame.
// [RULE11] - A complete loop mirrors all channels internally or externally.
// [RULE12] - A per-channel loop mirrors one selected channel internally or externally.
// [RULE13] - Up to 32 logical channels each have their own mode and slot allocation.
// [RULE14] - Subchanneling lets one slot be split among up to four devices by masked bits.
// [RULE15] - Transmit data is driven during active bits and released during inactive bits.
// [RULE16] - Serial paths are timed by their bit clocks and pass data through buffering.
package phsp_pkg;
   // Framing formats.
   typedef enum logic [1:0] {
      PHSP_FMT_2048 = 2'b00,
      PHSP_FMT_1544 = 2'b01,
      PHSP_FMT_1536 = 2'b10,
      PHSP_FMT_4096 = 2'b11
   } phsp_fmt_t;
   // Channel modes.
   typedef enum logic [1:0] {
      PHSP_MODE_HDLC = 2'b00,
      PHSP_MODE_TRANSPARENT_A = 2'b01,
      PHSP_MODE_TRANSPARENT_B = 2'b10,
      PHSP_MODE_TRANSPARENT_R = 2'b11
   } phsp_mode_t;
   // Loop types.
   typedef enum logic [2:0] {
      PHSP_LOOP_NONE = 3'b000,
      PHSP_LOOP_ALL_INT = 3'b001,
      PHSP_LOOP_ALL_EXT = 3'b010,
      PHSP_LOOP_CH_INT = 3'b011,
      PHSP_LOOP_CH_EXT = 3'b100
   } phsp_loop_t;
   localparam int PHSP_CHANNELS = 32;
   localparam int PHSP_SLOTS = 32;
   localparam logic [4:0] PHSP_SLOTS_24_LAST = 5'h17;
   localparam logic [4:0] PHSP_SLOTS_32_LAST = 5'h1f;
   // Register map, word offsets as byte addresses.
   localparam logic [7:0] PHSP_REG_CTRL = 8'h00;
   localparam logic [7:0] PHSP_REG_STAT = 8'h04;
   localparam logic [7:0] PHSP_REG_SLOT_SEL = 8'h08;
   localparam logic [7:0] PHSP_REG_SLOT_CFG = 8'h0c;
   localparam logic [7:0] PHSP_REG_CH_SEL = 8'h10;
   localparam logic [7:0] PHSP_REG_CH_MODE = 8'h14;
   localparam logic [7:0] PHSP_REG_TX_DATA = 8'h18;
   localparam logic [7:0] PHSP_REG_RX_DATA = 8'h1c;
   // Control register fields.
   localparam int PHSP_CTRL_EN = 0;
   localparam int PHSP_CTRL_FMT_LO = 1;
   localparam int PHSP_CTRL_ODD = 3;
   localparam int PHSP_CTRL_LOOP_LO = 4;
   localparam int PHSP_CTRL_LOOP_CH_LO = 8;
   localparam logic [31:0] PHSP_CTRL_RESET = 32'h0000_0000;
   // Slot config fields: bit 5 enable, bits 4:0 channel, bits 15:8 fill mask.
   localparam int PHSP_SLOT_EN = 5;
   localparam int PHSP_SLOT_MASK_LO = 8;
   localparam logic [7:0] PHSP_MASK_RESET = 8'hff;
   localparam int PHSP_SYNC_STAGES = 2;
   // One received slot byte with its channel.
   typedef struct packed {
      logic [4:0] channel;
      logic [7:0] bits;
      logic [7:0] valid;
   } phsp_word_t;
   typedef struct packed {
      logic en;
      logic [4:0] channel;
      logic [7:0] mask;
   } phsp_slot_t;
endpackage

// *** design/phsp_port.sv ***
// Time-division serial port between channel logic and a PCM highway.
`timescale 1ns/1ps
module phsp_port #(
   parameter int FIFO_DEPTH = 2
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Receive highway.
   input wire logic rx_bit_clock,
   input wire logic rx_frame_sync,
   input wire logic rx_data,
   // Transmit highway, enable low while driving.
   input wire logic tx_bit_clock,
   input wire logic tx_frame_sync,
   output logic tx_data,
   output logic tx_data_oe_n,
   // Received slot stream to the channel logic.
   output phsp_pkg::phsp_word_t rx_word,
   output logic rx_valid,
   input wire logic rx_ready
);
   logic [2:0] rclk_s, rsync_s, rdat_s, txclk_s, tsync_s;
   logic rclk_d, rsync_d, txclk_d, tsync_d;
   logic rx_rise, tx_fall, rsync_edge, tsync_edge;
   logic [8:0] rx_cur;
   logic [31:0] ctrl;
   phsp_pkg::phsp_slot_t slot_cfg [phsp_pkg::PHSP_SLOTS];
   phsp_pkg::phsp_mode_t ch_mode [phsp_pkg::PHSP_CHANNELS];
   logic [4:0] slot_sel, ch_sel;
   logic [7:0] tx_byte [phsp_pkg::PHSP_CHANNELS];
   logic [8:0] rx_pos, tx_pos;
   logic rx_fbit, tx_fbit, rx_act, tx_act;
   logic [5:0] rx_phys, tx_phys;
   logic [4:0] rx_slot, tx_slot;
   logic [2:0] rx_bit, tx_bit;
   logic [7:0] rx_sh, rx_vmask;
   logic rx_in, tx_out, loop_now_rx, loop_now_tx;
   logic rx_push, rx_full;
   logic [7:0] rx_overrun;
   phsp_pkg::phsp_word_t fifo [FIFO_DEPTH];
   logic [1:0] wr_ptr, rd_ptr, count;
   phsp_pkg::phsp_fmt_t fmt;
   phsp_pkg::phsp_loop_t loop_ty;
   logic [4:0] loop_ch;

   assign fmt = phsp_pkg::phsp_fmt_t'(ctrl[phsp_pkg::PHSP_CTRL_FMT_LO +: 2]);
   assign loop_ty = phsp_pkg::phsp_loop_t'(ctrl[phsp_pkg::PHSP_CTRL_LOOP_LO +: 3]);
   assign loop_ch = ctrl[phsp_pkg::PHSP_CTRL_LOOP_CH_LO +: 5];

   // Every pin passes two flops; the third stage only feeds edge detection.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rclk_s <= 3'h0;
         rsync_s <= 3'h0;
         rdat_s <= 3'h0;
         txclk_s <= 3'h0;
         tsync_s <= 3'h0;
      end else begin
         rclk_s <= {rclk_s[1:0], rx_bit_clock};
         rsync_s <= {rsync_s[1:0], rx_frame_sync};
         rdat_s <= {rdat_s[1:0], rx_data};
         txclk_s <= {txclk_s[1:0], tx_bit_clock};
         tsync_s <= {tsync_s[1:0], tx_frame_sync};
      end
   end
   assign rclk_d = rclk_s[2];
   assign rsync_d = rsync_s[2];
   assign txclk_d = txclk_s[2];
   assign tsync_d = tsync_s[2];
   // Receive samples on the rising bit clock edge, transmit changes on the falling one.
   // Edges are found about three system clocks late, which leaves margin only while the
   // bit clock runs well below a tenth of the system clock.
   assign rx_rise = rclk_s[1] & ~rclk_d;
   assign tx_fall = ~txclk_s[1] & txclk_d;

   // Sync is sampled with the bit clock; one edge per frame is assumed. [RULE10]
   // Both registers reset low, matching an idle sync pin, so no false frame start follows reset.
   logic rsync_q, tsync_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsync_q <= 1'b0;
         tsync_q <= 1'b0;
      end else begin
         if (rx_rise) begin
            rsync_q <= rsync_d;
         end
         if (tx_fall) begin
            tsync_q <= tsync_d;
         end
      end
   end
   assign rsync_edge = rx_rise & rsync_d & ~rsync_q;
   assign tsync_edge = tx_fall & tsync_d & ~tsync_q;
   // The bit on the line when the sync rise is seen is bit zero itself, not the one after it.
   assign rx_cur = rsync_edge ? 9'h000 : rx_pos; // [RULE7]

   // Separate bit counters per direction keep the two frames unrelated. [RULE1]
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_pos <= 9'h000;
      end else if (rsync_edge) begin
         rx_pos <= 9'h001; // [RULE7]
      end else if (rx_rise) begin
         rx_pos <= rx_pos + 9'h001;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_pos <= 9'h000;
      end else if (tsync_edge) begin
         tx_pos <= 9'h000; // [RULE6]
      end else if (tx_fall) begin
         tx_pos <= tx_pos + 9'h001;
      end
   end

   // Map a bit position to physical slot and bit; F bit leads 1.544 frames. [RULE2] [RULE8]
   function automatic logic [9:0] map_pos(input logic [8:0] pos, input phsp_pkg::phsp_fmt_t f);
      logic [8:0] p;
      p = pos;
      map_pos = {1'b0, p[8:3], p[2:0]};
      if (f == phsp_pkg::PHSP_FMT_1544) begin
         if (pos == 9'h000) begin
            map_pos = {1'b1, 9'h000};
         end else begin
            p = pos - 9'h001;
            map_pos = {1'b0, p[8:3], p[2:0]};
         end
      end
   endfunction

   always_comb begin
      {rx_fbit, rx_phys, rx_bit} = map_pos(rx_cur, fmt);
      {tx_fbit, tx_phys, tx_bit} = map_pos(tx_pos, fmt);
   end

   // In 4.096 mode only slots of the chosen parity belong to this port. [RULE3]
   function automatic logic slot_ok(input logic fb, input logic [5:0] ph,
                                    input phsp_pkg::phsp_fmt_t f, input logic odd);
      slot_ok = !fb;
      unique case (f)
         phsp_pkg::PHSP_FMT_4096: slot_ok = !fb && (ph[0] == odd);
         phsp_pkg::PHSP_FMT_2048: slot_ok = !fb && (ph[4:0] <= phsp_pkg::PHSP_SLOTS_32_LAST)
                                            && !ph[5];
         phsp_pkg::PHSP_FMT_1544,
         phsp_pkg::PHSP_FMT_1536: slot_ok = !fb && (ph[4:0] <= phsp_pkg::PHSP_SLOTS_24_LAST)
                                            && !ph[5];
      endcase
   endfunction

   always_comb begin
      rx_slot = (fmt == phsp_pkg::PHSP_FMT_4096) ? rx_phys[5:1] : rx_phys[4:0];
      tx_slot = (fmt == phsp_pkg::PHSP_FMT_4096) ? tx_phys[5:1] : tx_phys[4:0];
      // Fill mask bit gates each bit, which also splits a slot among devices. [RULE4] [RULE14]
      rx_act = ctrl[phsp_pkg::PHSP_CTRL_EN]
               && slot_ok(rx_fbit, rx_phys, fmt, ctrl[phsp_pkg::PHSP_CTRL_ODD])
               && slot_cfg[rx_slot].en && slot_cfg[rx_slot].mask[3'h7 - rx_bit];
      tx_act = ctrl[phsp_pkg::PHSP_CTRL_EN]
               && slot_ok(tx_fbit, tx_phys, fmt, ctrl[phsp_pkg::PHSP_CTRL_ODD])
               && slot_cfg[tx_slot].en && slot_cfg[tx_slot].mask[3'h7 - tx_bit];
      loop_now_tx = (loop_ty == phsp_pkg::PHSP_LOOP_ALL_EXT)
                    || (loop_ty == phsp_pkg::PHSP_LOOP_CH_EXT
                        && slot_cfg[tx_slot].channel == loop_ch);
      loop_now_rx = (loop_ty == phsp_pkg::PHSP_LOOP_ALL_INT)
                    || (loop_ty == phsp_pkg::PHSP_LOOP_CH_INT
                        && slot_cfg[rx_slot].channel == loop_ch);
      // Loops: internal feeds transmit bits back in, external echoes received bits. [RULE11] [RULE12]
      // The internal loop reads the transmit register as it stands when a receive bit is
      // sampled, so it mirrors cleanly only when both highway clocks run at one rate.
      rx_in = loop_now_rx ? tx_data : rdat_s[1];
      tx_out = loop_now_tx ? rdat_s[1] : tx_byte[slot_cfg[tx_slot].channel][3'h7 - tx_bit];
   end

   // Transmit pin: driven on active bits only, released on F bit and masked bits. [RULE15] [RULE8]
   // After reset the pin idles released, so a shared highway sees no stray drive.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_data <= 1'b1;
         tx_data_oe_n <= 1'b1;
      end else if (tx_fall) begin
         tx_data <= tx_out;
         tx_data_oe_n <= !tx_act;
      end
   end

   // Receive shift: masked bits are ones in mode A, else flagged invalid. [RULE9] [RULE5]
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_sh <= 8'h00;
         rx_vmask <= 8'h00;
      end else if (rx_rise && !rx_fbit) begin
         rx_sh[3'h7 - rx_bit] <= rx_act ? rx_in : 1'b1;
         rx_vmask[3'h7 - rx_bit] <= rx_act
            || ch_mode[slot_cfg[rx_slot].channel] == phsp_pkg::PHSP_MODE_TRANSPARENT_A;
      end
   end
   assign rx_push = rx_rise && !rx_fbit && rx_bit == 3'h7 && ctrl[phsp_pkg::PHSP_CTRL_EN]
                    && slot_ok(rx_fbit, rx_phys, fmt, ctrl[phsp_pkg::PHSP_CTRL_ODD])
                    && slot_cfg[rx_slot].en;
   assign rx_full = (count == 2'(FIFO_DEPTH));

   // Slot words queue toward the channel logic so a short stall loses nothing. [RULE16] [RULE13]
   // The output register holds the queue head, so two words ride out a stall; a longer
   // stall drops new words and counts them, since the highway cannot be paused.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= 2'h0;
         rd_ptr <= 2'h0;
         count <= 2'h0;
         rx_overrun <= 8'h00;
      end else begin
         if (rx_push && !rx_full) begin
            fifo[wr_ptr[0]] <= '{channel: slot_cfg[rx_slot].channel,
                                 bits: {rx_sh[7:1], rx_act ? rx_in : 1'b1},
                                 valid: {rx_vmask[7:1], rx_act
                                    || ch_mode[slot_cfg[rx_slot].channel]
                                       == phsp_pkg::PHSP_MODE_TRANSPARENT_A}};
            wr_ptr <= wr_ptr + 2'h1;
         end
         if (rx_push && rx_full && rx_overrun != 8'hff) begin
            rx_overrun <= rx_overrun + 8'h01;
         end
         if (rx_valid && rx_ready) begin
            rd_ptr <= rd_ptr + 2'h1;
         end
         count <= count + 2'((rx_push && !rx_full) ? 1 : 0)
                  - 2'((rx_valid && rx_ready) ? 1 : 0);
      end
   end

   // Output stage registered from the queue head.
   // Loading only when empty or accepted keeps the word stable while the sink stalls.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_valid <= 1'b0;
         rx_word <= '0;
      end else if (!rx_valid || rx_ready) begin
         rx_valid <= (count > 2'(rx_valid && rx_ready ? 1 : 0));
         rx_word <= fifo[rx_valid && rx_ready ? !rd_ptr[0] : rd_ptr[0]];
      end
   end

   // Register writes: slot assignment, channel mode, per-channel transmit byte. [RULE13]
   // Slot and channel tables are reached through select registers, which keeps the map small
   // at the cost of two writes per table entry.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= phsp_pkg::PHSP_CTRL_RESET;
         slot_sel <= 5'h00;
         ch_sel <= 5'h00;
         for (int i = 0; i < phsp_pkg::PHSP_SLOTS; i++) begin
            slot_cfg[i] <= '{en: 1'b0, channel: 5'h00, mask: phsp_pkg::PHSP_MASK_RESET};
         end
         for (int i = 0; i < phsp_pkg::PHSP_CHANNELS; i++) begin
            ch_mode[i] <= phsp_pkg::PHSP_MODE_HDLC;
            tx_byte[i] <= 8'hff;
         end
      end else if (reg_write) begin
         unique case (reg_addr)
            phsp_pkg::PHSP_REG_CTRL: ctrl <= reg_wdata;
            phsp_pkg::PHSP_REG_SLOT_SEL: slot_sel <= reg_wdata[4:0];
            phsp_pkg::PHSP_REG_SLOT_CFG: slot_cfg[slot_sel] <= '{
               en: reg_wdata[phsp_pkg::PHSP_SLOT_EN], channel: reg_wdata[4:0],
               mask: reg_wdata[phsp_pkg::PHSP_SLOT_MASK_LO +: 8]};
            phsp_pkg::PHSP_REG_CH_SEL: ch_sel <= reg_wdata[4:0];
            phsp_pkg::PHSP_REG_CH_MODE: ch_mode[ch_sel] <= phsp_pkg::phsp_mode_t'(reg_wdata[1:0]);
            phsp_pkg::PHSP_REG_TX_DATA: tx_byte[ch_sel] <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Reads answer the cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         unique case (reg_addr)
            phsp_pkg::PHSP_REG_CTRL: reg_rdata <= ctrl;
            // Status: overrun count, receive slot and the low bits of the transmit position.
            phsp_pkg::PHSP_REG_STAT: reg_rdata <= {8'h00, rx_overrun, 3'h0, rx_slot,
                                                   tx_pos[7:0]};
            phsp_pkg::PHSP_REG_SLOT_SEL: reg_rdata <= {27'h000_0000, slot_sel};
            phsp_pkg::PHSP_REG_SLOT_CFG: reg_rdata <= {16'h0000, slot_cfg[slot_sel].mask,
                                                       2'h0, slot_cfg[slot_sel].en,
                                                       slot_cfg[slot_sel].channel};
            phsp_pkg::PHSP_REG_CH_SEL: reg_rdata <= {27'h000_0000, ch_sel};
            phsp_pkg::PHSP_REG_CH_MODE: reg_rdata <= {30'h0000_0000, ch_mode[ch_sel]};
            phsp_pkg::PHSP_REG_TX_DATA: reg_rdata <= {24'h00_0000, tx_byte[ch_sel]};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule

// *** verif/phsp_port_properties.sv ***
// Port-level concurrent checks for the PCM highway serial port.
`timescale 1ns/1ps
module phsp_port_properties (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // Highway and stream.
   input wire logic tx_bit_clock,
   input wire logic tx_data,
   input wire logic tx_data_oe_n,
   input wire phsp_pkg::phsp_word_t rx_word,
   input wire logic rx_valid,
   input wire logic rx_ready
);
   logic [12:0] ctrl;
   logic clk_q;
   logic [3:0] age;
   logic [5:0] off_age;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= 13'h0000;
      end else if (reg_write && reg_addr == phsp_pkg::PHSP_REG_CTRL) begin
         ctrl <= reg_wdata[12:0];
      end
   end
   // Cycles since the transmit clock pin fell; it saturates so a stopped clock cannot wrap.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_q <= 1'b0;
         age <= 4'hf;
      end else begin
         clk_q <= tx_bit_clock;
         age <= (clk_q && !tx_bit_clock) ? 4'h0 : age + 4'(age != 4'hf);
      end
   end
   // Cycles since the port was disabled; the pin may only release at the next bit clock fall.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         off_age <= 6'h00;
      end else begin
         off_age <= ctrl[0] ? 6'h00 : off_age + 6'(off_age != 6'h3f);
      end
   end
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
      else $error("read data present without a read");
   a_ctrl_readback: assert property (reg_read && reg_addr == phsp_pkg::PHSP_REG_CTRL |=>
      (reg_rdata[12:0] & 13'h1f7f) == (ctrl & 13'h1f7f))
      else $error("control read back differs from last write");
   a_unmapped_zero: assert property (reg_read && reg_addr > phsp_pkg::PHSP_REG_RX_DATA |=>
      reg_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");
   a_word_held: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
      else $error("stalled word changed or vanished");
   a_quiet_disabled: assert property (off_age == 6'h3f |-> tx_data_oe_n)
      else $error("transmit driven while port disabled");
   a_txd_timing: assert property ($changed(tx_data) |-> age inside {[4'h1:4'h5]})
      else $error("transmit data moved away from a falling bit clock");
   a_oe_timing: assert property ($changed(tx_data_oe_n) |-> age inside {[4'h1:4'h5]})
      else $error("transmit enable moved away from a falling bit clock");
   a_word_nonempty: assert property (rx_valid |-> rx_word.valid != 8'h00)
      else $error("word offered with no used bits");
endmodule

// *** verif/phsp_highway_model.sv ***
// Behavioural PCM highway framer that clocks both directions and captures transmit slot 0.
`timescale 1ns/1ps
module phsp_highway_model #(
   parameter int FRAME_BITS = 256,
   parameter logic [7:0] RX_PATTERN = 8'ha5
) (
   // Receive highway.
   output logic rx_bit_clock,
   output logic rx_frame_sync,
   output logic rx_data,
   // Transmit highway.
   output logic tx_bit_clock,
   output logic tx_frame_sync,
   input wire logic tx_data,
   input wire logic tx_data_oe_n,
   // Last complete transmit frame.
   output logic [7:0] tx_slot0,
   output int tx_driven,
   output int tx_frames
);
   int rx_pos = FRAME_BITS - 1;
   int tx_pos = FRAME_BITS - 1;
   int cnt = 0;
   logic [7:0] cap = 8'h00;
   initial begin
      rx_bit_clock = 1'b0;
      rx_frame_sync = 1'b0;
      rx_data = 1'b1;
      tx_bit_clock = 1'b0;
      tx_frame_sync = 1'b0;
      tx_frames = 0;
      // The transmit clock starts out of phase so the two directions stay unrelated.
      #31;
      forever #62.5 tx_bit_clock = ~tx_bit_clock;
   end
   // A small offset keeps receive clock edges off the system clock edges.
   initial begin
      #1;
      forever #62.5 rx_bit_clock = ~rx_bit_clock;
   end
   // Bits move on the falling edge, half a bit away from the port's sampling edge.
   always @(negedge rx_bit_clock) begin
      rx_pos = (rx_pos + 1) % FRAME_BITS;
      rx_frame_sync <= rx_pos == 0;
      rx_data <= RX_PATTERN[7 - rx_pos % 8];
   end
   always @(negedge tx_bit_clock) tx_pos = (tx_pos + 1) % FRAME_BITS;
   always @(posedge tx_bit_clock) begin
      cnt += int'(tx_data_oe_n === 1'b0);
      if (tx_pos < 8) cap[7 - tx_pos] = tx_data;
      if (tx_pos == FRAME_BITS - 1) begin
         tx_slot0 <= cap;
         tx_driven <= cnt;
         tx_frames <= tx_frames + 1;
         cnt = 0;
      end
      // Raised before the falling edge that launches the last bit, dropped one bit later.
      tx_frame_sync <= tx_pos == FRAME_BITS - 2;
   end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the PCM highway serial port.
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic rx_ready = 1'b1;
   logic [31:0] reg_rdata;
   logic [31:0] d;
   logic rx_bit_clock, rx_frame_sync, rx_data, tx_bit_clock, tx_frame_sync, tx_data;
   logic tx_data_oe_n, rx_valid;
   logic [7:0] tx_slot0, exp_b, exp_v;
   phsp_pkg::phsp_word_t rx_word;
   phsp_pkg::phsp_word_t last [32];
   int tx_driven, tx_frames, failures = 0, comparisons = 0, cycles = 0;
   phsp_port i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync), .rx_data(rx_data),
      .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync), .tx_data(tx_data),
      .tx_data_oe_n(tx_data_oe_n), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
   phsp_highway_model i_highway (.rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
      .rx_data(rx_data), .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
      .tx_data(tx_data), .tx_data_oe_n(tx_data_oe_n), .tx_slot0(tx_slot0),
      .tx_driven(tx_driven), .tx_frames(tx_frames));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) last[rx_word.channel] <= rx_word;
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         failures++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // Only the used bits of a word are compared; dropped bits read as ones but are flagged invalid.
   task automatic check_word(input logic [4:0] ch, input logic [7:0] b, input logic [7:0] v);
      check({11'h000, last[ch].channel, last[ch].bits & last[ch].valid, last[ch].valid},
         {11'h000, ch, b, v});
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic frames(input int n);
      int f;
      last = '{default: '0};
      f = tx_frames + n;
      wait (tx_frames >= f);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      reg_rd(phsp_pkg::PHSP_REG_CTRL);
      check(d, phsp_pkg::PHSP_CTRL_RESET);
      reg_wr(8'h40, 32'hffff_ffff);
      reg_rd(8'h40);
      check(d, 32'h0000_0000);
      reg_wr(phsp_pkg::PHSP_REG_CH_SEL, 32'h0000_0003);
      reg_wr(phsp_pkg::PHSP_REG_TX_DATA, 32'h0000_003c);
      reg_wr(phsp_pkg::PHSP_REG_SLOT_SEL, 32'h0000_0000);
      reg_wr(phsp_pkg::PHSP_REG_SLOT_CFG, 32'h0000_ff23);
      for (int m = 0; m < 4; m++) begin
         reg_wr(phsp_pkg::PHSP_REG_SLOT_SEL, 32'(m + 1));
         reg_wr(phsp_pkg::PHSP_REG_SLOT_CFG, 32'h0000_f024 + 32'(m));
         reg_wr(phsp_pkg::PHSP_REG_CH_SEL, 32'(m + 4));
         reg_wr(phsp_pkg::PHSP_REG_CH_MODE, 32'(m));
      end
      reg_wr(phsp_pkg::PHSP_REG_CTRL, 32'h0000_0001);
      reg_rd(phsp_pkg::PHSP_REG_CTRL);
      check(d, 32'h0000_0001);
      frames(3);
      check_word(5'h03, 8'ha5, 8'hff);
      for (int m = 0; m < 4; m++) begin
         exp_b = (m == 1) ? 8'haf : 8'ha0;
         exp_v = (m == 1) ? 8'hff : 8'hf0;
         check_word(5'(m + 4), exp_b, exp_v);
      end
      check({24'h00_0000, tx_slot0}, 32'h0000_003c);
      check(tx_driven, 32'h0000_0018);
      rx_ready <= 1'b0;
      frames(1);
      reg_rd(phsp_pkg::PHSP_REG_STAT);
      check(32'(d[23:16] != 8'h00), 32'h0000_0001);
      rx_ready <= 1'b1;
      for (int i = 1; i <= 4; i++) begin
         reg_wr(phsp_pkg::PHSP_REG_CTRL, 32'h0000_0301 | 32'(i << 4));
         frames(2);
         if (i % 2 == 1) check_word(5'h03, 8'h3c, 8'hff);
         else check({24'h00_0000, tx_slot0}, 32'h0000_00a5);
      end
      reg_wr(phsp_pkg::PHSP_REG_CTRL, 32'h0000_0000);
      repeat (40) @(posedge clk);
      check({31'h0000_0000, tx_data_oe_n}, 32'h0000_0001);
      final_report();
   end
endmodule
bind phsp_port phsp_port_properties i_props (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .tx_bit_clock(tx_bit_clock), .tx_data(tx_data), .tx_data_oe_n(tx_data_oe_n),
   .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
